/* File: verilog/scgr_pkg.sv */
// Package for the system clock gate and reset source block
`default_nettype none
package scgr_pkg;
    // Register byte addresses
    localparam logic [31:0] GATES_ADDR   = 32'hE01FC0C4;
    localparam logic [31:0] DIVIDER_ADDR = 32'hE01FC100;
    localparam logic [31:0] SOURCE_ADDR  = 32'hE01FC180;
    // Gate register reset value and writable mask: bits 1-5, 7-12,
    // 19 and 20; reserved bits 18:13 must stay out of the mask
    localparam logic [31:0] GATES_RESET  = 32'h00181FBE;
    localparam logic [31:0] GATES_MASK   = 32'h00181FBE;
    // Gate bit positions
    localparam int TIMER_A_BIT    = 1;
    localparam int TIMER_B_BIT    = 2;
    localparam int SERIAL_A_BIT   = 3;
    localparam int SERIAL_B_BIT   = 4;
    localparam int PWM_BIT        = 5;
    localparam int TWOWIRE_A_BIT  = 7;
    localparam int SYNC_A_BIT     = 8;
    localparam int CALENDAR_BIT   = 9;
    localparam int SYNC_B_BIT     = 10;
    localparam int SPARE_BIT      = 11;
    localparam int CONV_A_BIT     = 12;
    localparam int TWOWIRE_B_BIT  = 19;
    localparam int CONV_B_BIT     = 20;
    localparam int NUM_UNITS      = 12;
    // Divider encodings
    localparam logic [1:0] DIV_QUARTER  = 2'h0;
    localparam logic [1:0] DIV_FULL     = 2'h1;
    localparam logic [1:0] DIV_HALF     = 2'h2;
    localparam logic [1:0] DIV_RESERVED = 2'h3;
    // Source flag positions
    localparam int POWER_ON_FLAG = 0;
    localparam int PIN_FLAG      = 1;
    localparam int WATCHDOG_FLAG = 2;
    localparam int BROWNOUT_FLAG = 3;
    // Timing: wakeup count in oscillator clocks, glitch filter width
    localparam int WAKE_CLOCKS   = 4096;
    localparam int CLK_PERIOD_NS = 10;
    localparam int FILTER_NS     = 300;
    localparam int FILTER_CYCLES = FILTER_NS / CLK_PERIOD_NS;
    localparam int BOOT_VECTOR   = 0;
    // Register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } scgr_req_type;
    // Reset sequencer states
    typedef enum logic [2:0] {
        ST_HOLD, ST_OSC, ST_COUNT, ST_INIT, ST_FLASH, ST_RUN
    } scgr_state_type;
endpackage
`default_nettype wire

/* File: verilog/scgr_top.sv */
// Clock gating, peripheral divider and reset sequencing
`default_nettype none
module scgr_top
    import scgr_pkg::*;
#(
    parameter int WAKE_COUNT = scgr_pkg::WAKE_CLOCKS, // Wakeup clocks
    parameter int CFG_W      = 2                      // Config pins
) (
    input  wire logic                   mclk_i,        // Processor clock
    input  wire logic                   rst_n_i,       // Async reset
    input  wire scgr_pkg::scgr_req_type req_i,         // Register access
    output logic [31:0]                 rdata_o,       // Read data
    input  wire logic                   pin_reset_n_i, // Board reset pin
    input  wire logic                   power_on_i,    // Power-on reset
    input  wire logic                   watchdog_i,    // Watchdog timeout
    input  wire logic                   wd_enable_i,   // Watchdog reset en
    input  wire logic                   brownout_i,    // Brownout reset
    input  wire logic                   osc_ok_i,      // Oscillator running
    input  wire logic                   init_done_i,   // On-chip init done
    input  wire logic                   flash_busy_i,  // Flash operating
    input  wire logic                   flash_hv_ok_i, // Flash volts settled
    input  wire logic                   idle_i,        // Processor idle
    input  wire logic [CFG_W-1:0]       cfg_pins_i,    // Config pins
    output logic                        sys_reset_n_o, // Internal reset
    output logic                        flash_abort_o, // Flash abort
    output logic                        init_en_o,     // Start init
    output logic [31:0]                 fetch_addr_o,  // Boot fetch address
    output logic [CFG_W-1:0]            cfg_latch_o,   // Latched config
    output logic                        pll_keep_o,    // Keep pll running
    output logic                        pclk_en_o,     // Peripheral tick
    output logic [NUM_UNITS-1:0]        unit_en_o      // Per unit clock en
);
    import scgr_pkg::*;

    // Local reset released through two flops
    logic rst_s1_q, rst_n_q;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // Registers
    logic [31:0] gates_q;    // Gate register
    logic [1:0]  div_q;      // Divider select
    logic [3:0]  src_q;      // Source flags
    logic [3:0]  src_d;      // Next source flags
    logic        wr_gates, wr_div, wr_src;

    assign wr_gates = req_i.wr && (req_i.addr == GATES_ADDR);
    assign wr_div   = req_i.wr && (req_i.addr == DIVIDER_ADDR);
    assign wr_src   = req_i.wr && (req_i.addr == SOURCE_ADDR);

    // Pin glitch filter: must stay low the full filter window
    logic [7:0] filt_q;      // Low-time counter
    logic       pin_rst_q;   // Filtered pin reset, active high
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            filt_q    <= 8'h00;
            pin_rst_q <= 1'b0;
        end else if (pin_reset_n_i) begin
            filt_q    <= 8'h00;
            pin_rst_q <= 1'b0;
        end else if (filt_q == 8'(FILTER_CYCLES - 1)) begin
            pin_rst_q <= 1'b1;
        end else begin
            filt_q <= filt_q + 8'h01;
        end
    end

    // Gate register; only defined bits are stored, reserved read zero
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            gates_q <= GATES_RESET;
        end else if (!sys_reset_n_o) begin
            gates_q <= GATES_RESET;
        end else if (wr_gates) begin
            gates_q <= req_i.wdata & GATES_MASK;
        end
    end

    // Divider select; reserved code keeps old ratio
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_q <= DIV_QUARTER;
        end else if (!sys_reset_n_o) begin
            div_q <= DIV_QUARTER;
        end else if (wr_div && req_i.wdata[1:0] != DIV_RESERVED) begin
            div_q <= req_i.wdata[1:0];
        end
    end

    // Source flags: set beats the software clear
    always_comb begin
        src_d = src_q;
        if (wr_src) begin
            src_d = src_q & ~req_i.wdata[3:0];
        end
        if (power_on_i) begin
            src_d = 4'h1;
        end else begin
            if (pin_rst_q) begin
                src_d[PIN_FLAG] = 1'b1;
                src_d[WATCHDOG_FLAG] = 1'b0;
            end
            if (brownout_i) begin
                src_d[BROWNOUT_FLAG] = 1'b1;
                src_d[WATCHDOG_FLAG] = 1'b0;
            end
            if (watchdog_i && wd_enable_i) begin
                src_d[WATCHDOG_FLAG] = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            src_q <= 4'h1;
        end else begin
            src_q <= src_d;
        end
    end

    // Reset sequencer: any source restarts wake sequence
    scgr_state_type st_q;
    logic [12:0]    wake_q;  // Wakeup clock counter
    logic           any_rst;
    assign any_rst = power_on_i || pin_rst_q || brownout_i ||
                     (watchdog_i && wd_enable_i);

    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q   <= ST_HOLD;
            wake_q <= 13'h0000;
        end else if (any_rst) begin
            st_q   <= ST_HOLD;
            wake_q <= 13'h0000;
        end else begin
            case (st_q)
                ST_HOLD: if (pin_reset_n_i) begin
                    st_q <= ST_OSC;
                end
                ST_OSC: if (osc_ok_i) begin
                    st_q <= ST_COUNT;
                end
                ST_COUNT: begin
                    if (!osc_ok_i) begin
                        st_q   <= ST_OSC;
                        wake_q <= 13'h0000;
                    end else if (wake_q == 13'(WAKE_COUNT - 1)) begin
                        st_q <= ST_INIT;
                    end else begin
                        wake_q <= wake_q + 13'h0001;
                    end
                end
                ST_INIT: if (init_done_i) begin
                    st_q <= ST_FLASH;
                end
                ST_FLASH: if (flash_hv_ok_i) begin
                    st_q <= ST_RUN;
                end
                ST_RUN: st_q <= ST_RUN;
                default: st_q <= ST_HOLD;
            endcase
        end
    end

    // Reset outputs
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sys_reset_n_o <= 1'b0;
            flash_abort_o <= 1'b0;
            init_en_o     <= 1'b0;
            fetch_addr_o  <= 32'h00000000;
        end else begin
            sys_reset_n_o <= (st_q == ST_RUN) && !any_rst;
            flash_abort_o <= any_rst && flash_busy_i;
            init_en_o     <= (st_q == ST_INIT);
            fetch_addr_o  <= 32'(BOOT_VECTOR);
        end
    end

    // Config latch: pin reset only, caught at pin release
    logic pin_rst_prev_q;
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_rst_prev_q <= 1'b0;
            cfg_latch_o    <= '0;
        end else begin
            pin_rst_prev_q <= pin_rst_q;
            if (pin_rst_prev_q && pin_reset_n_i) begin
                cfg_latch_o <= cfg_pins_i;
            end
        end
    end

    // Divider: tick counter restarts only at a period boundary
    logic [1:0] cnt_q;    // Tick phase
    logic [1:0] act_q;    // Ratio in effect
    logic       wrap;
    assign wrap = (act_q == DIV_FULL) ||
                  (act_q == DIV_HALF && cnt_q[0]) ||
                  (act_q == DIV_QUARTER && cnt_q == 2'h3);
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cnt_q     <= 2'h0;
            act_q     <= DIV_QUARTER;
            pclk_en_o <= 1'b0;
        end else begin
            pclk_en_o <= wrap;
            if (wrap) begin
                cnt_q <= 2'h0;
                act_q <= div_q;
            end else begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end

    // Per unit enables follow the gate bits at tick boundaries
    localparam int UNIT_POS [NUM_UNITS] = '{TIMER_A_BIT, TIMER_B_BIT,
        SERIAL_A_BIT, SERIAL_B_BIT, PWM_BIT, TWOWIRE_A_BIT, SYNC_A_BIT,
        CALENDAR_BIT, SYNC_B_BIT, CONV_A_BIT, TWOWIRE_B_BIT, CONV_B_BIT};
    genvar g;
    generate
        for (g = 0; g < NUM_UNITS; g++) begin : g_unit
            always_ff @(posedge mclk_i or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    unit_en_o[g] <= 1'b1;
                end else if (wrap) begin
                    unit_en_o[g] <= gates_q[UNIT_POS[g]];
                end
            end
        end
    endgenerate

    // Pll hold and read data
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pll_keep_o <= 1'b1;
            rdata_o    <= 32'h00000000;
        end else begin
            pll_keep_o <= 1'b1;
            if (!req_i.rd) begin
                rdata_o <= 32'h00000000;
            end else begin
                case (req_i.addr)
                    GATES_ADDR:   rdata_o <= gates_q;
                    DIVIDER_ADDR: rdata_o <= {30'h0, div_q};
                    SOURCE_ADDR:  rdata_o <= {28'h0, src_q};
                    default:      rdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    // Checks, all on the processor clock and the local reset
    // Reserved divider code leaves the ratio alone
    chk_div_reserved: assert property (@(posedge mclk_i)
        disable iff (!rst_n_q) wr_div && sys_reset_n_o &&
        req_i.wdata[1:0] == DIV_RESERVED |=> $stable(div_q))
        else $error("divider took reserved code");
    // Clear of the brownout flag while brownout is quiet takes effect
    chk_src_clear: assert property (@(posedge mclk_i)
        disable iff (!rst_n_q) wr_src && req_i.wdata[3] && !brownout_i &&
        !power_on_i |=> !src_q[3])
        else $error("source flag not cleared");
    // Power-on leaves only its own flag
    chk_por_flags: assert property (@(posedge mclk_i)
        disable iff (!rst_n_q) power_on_i |=> src_q == 4'h1)
        else $error("power-on flags wrong");
    // Each armed source sets its own flag one cycle later
    chk_pin_flag: assert property (@(posedge mclk_i)
        disable iff (!rst_n_q) pin_rst_q && !power_on_i |=> src_q[1])
        else $error("pin flag not set");
    chk_wd_flag: assert property (@(posedge mclk_i)
        disable iff (!rst_n_q) watchdog_i && wd_enable_i && !power_on_i
        |=> src_q[2])
        else $error("watchdog flag not set");
    chk_bo_flag: assert property (@(posedge mclk_i)
        disable iff (!rst_n_q) brownout_i && !power_on_i |=> src_q[3])
        else $error("brownout flag not set");
    // Internal reset stays low at least two cycles after a source
    chk_hold_reset: assert property (@(posedge mclk_i)
        disable iff (!rst_n_q) any_rst |=> !sys_reset_n_o [*2])
        else $error("reset released too soon");
    chk_flash_abort: assert property (@(posedge mclk_i)
        disable iff (!rst_n_q) any_rst && flash_busy_i |=> flash_abort_o)
        else $error("flash not aborted");
    // Release only after the flash reported settled volts
    chk_release_hv: assert property (@(posedge mclk_i)
        disable iff (!rst_n_q) $rose(sys_reset_n_o) |-> $past(flash_hv_ok_i))
        else $error("released before flash settled");
    // Reserved gate bits never hold a one
    chk_gate_rsvd: assert property (@(posedge mclk_i)
        disable iff (!rst_n_q) (gates_q & ~GATES_MASK) == 32'h0)
        else $error("reserved gate bit set");
    // Quarter rate leaves three quiet cycles between ticks
    chk_quarter_tick: assert property (@(posedge mclk_i)
        disable iff (!rst_n_q) pclk_en_o && act_q == DIV_QUARTER &&
        div_q == DIV_QUARTER |=> !pclk_en_o [*3])
        else $error("quarter tick spacing");
    // A pin reset only after the full low window was counted
    chk_filter_span: assert property (@(posedge mclk_i)
        disable iff (!rst_n_q) $rose(pin_rst_q) |->
        $past(filt_q) == 8'(FILTER_CYCLES - 1))
        else $error("pin reset before filter window");
    // Main scenarios worth seeing in a run
    cov_wd_reset: cover property (@(posedge mclk_i) watchdog_i && wd_enable_i);
    cov_release: cover property (@(posedge mclk_i) $rose(sys_reset_n_o));
    cov_half: cover property (@(posedge mclk_i) act_q == DIV_HALF);
    cov_pin_reset: cover property (@(posedge mclk_i) $rose(pin_rst_q));
    cov_div_reserved: cover property (@(posedge mclk_i)
        wr_div && req_i.wdata[1:0] == DIV_RESERVED);
endmodule
`default_nettype wire

/* File: testbench/scgr_partner.sv */
// Board reset driver and on-chip responders for the reset sequencer
`default_nettype none
module scgr_partner (
    input  wire logic       mclk_i,          // Processor clock
    input  wire logic       go_i,            // Start a pin pulse
    input  wire logic [7:0] len_i,           // Pulse length in cycles
    input  wire logic       init_en_i,       // Init request from sequencer
    input  wire logic       abort_i,         // Flash abort from sequencer
    output logic            pin_n_o = 1'b1,  // Board reset pin
    output logic            osc_ok_o = 1'b0, // Oscillator running
    output logic            done_o = 1'b0,   // Init finished
    output logic            hv_ok_o = 1'b1   // Flash volts settled
);
    timeunit 1ns;
    timeprecision 1ps;
    int pin_cnt  = 0; // Pin low cycles left
    int osc_cnt  = 0; // Oscillator start-up count
    int init_cnt = 0; // Cycles of init seen
    int hv_cnt   = 0; // Cycles until volts settle
    // Counters advance on the rising edge, where requests are stable
    always @(posedge mclk_i) begin
        if (go_i) pin_cnt = len_i;
        else if (pin_cnt > 0) pin_cnt--;
        if (osc_cnt < 5) osc_cnt++;
        init_cnt = init_en_i ? init_cnt + 1 : 0;
        // Aborted flash needs time before its volts settle
        if (abort_i) hv_cnt = 20;
        else if (hv_cnt > 0) hv_cnt--;
    end
    // Pins change on the falling edge, away from design sampling
    always @(negedge mclk_i) begin
        pin_n_o  <= (pin_cnt == 0);
        osc_ok_o <= (osc_cnt == 5);
        done_o   <= (init_cnt > 3);
        hv_ok_o  <= (hv_cnt == 0);
    end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the clock gate and reset source block
`default_nettype none
module tb;
    import scgr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;      // Clock
    logic rst_n_i = 1'b0;     // Reset
    scgr_req_type req = '0;   // Register request
    logic [31:0] rdata;       // Read data
    logic pin_n, osc_ok, done, hv_ok, sys_n, abort, init_en, pll, tick;
    logic pwr = 1'b1;         // Power-on level
    logic wdog = 1'b0;        // Watchdog timeout
    logic wd_en = 1'b1;       // Watchdog reset enable
    logic brownout_detector = 1'b0;         // Brownout level
    logic busy = 1'b0;        // Flash operating
    logic idle = 1'b0;        // Processor idle
    logic [1:0] cfg = 2'h0;   // Config pins
    logic [1:0] cfg_l;        // Latched config
    logic [31:0] fetch;       // Boot fetch address
    logic [NUM_UNITS-1:0] units; // Unit clock enables
    logic go = 1'b0;          // Pin pulse start
    logic [7:0] len = 8'h00;  // Pin pulse length
    int error_cnt = 0;        // Mismatches
    int compares = 0;         // Comparisons
    int cycles = 0;           // Timeout counter
    always #5 mclk_i = ~mclk_i;
    scgr_top #(.WAKE_COUNT(8), .CFG_W(2)) DUT (.mclk_i(mclk_i),
        .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rdata),
        .pin_reset_n_i(pin_n), .power_on_i(pwr), .watchdog_i(wdog),
        .wd_enable_i(wd_en), .brownout_i(brownout_detector), .osc_ok_i(osc_ok),
        .init_done_i(done), .flash_busy_i(busy), .flash_hv_ok_i(hv_ok),
        .idle_i(idle), .cfg_pins_i(cfg), .sys_reset_n_o(sys_n),
        .flash_abort_o(abort), .init_en_o(init_en), .fetch_addr_o(fetch),
        .cfg_latch_o(cfg_l), .pll_keep_o(pll), .pclk_en_o(tick),
        .unit_en_o(units));
    scgr_partner board (.mclk_i(mclk_i), .go_i(go), .len_i(len),
        .init_en_i(init_en), .abort_i(abort), .pin_n_o(pin_n),
        .osc_ok_o(osc_ok), .done_o(done), .hv_ok_o(hv_ok));
    task automatic print_verdict();
        if (error_cnt == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One compare for all word results
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(logic [31:0] a, logic [31:0] d);
        @(negedge mclk_i);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge mclk_i);
        req.wr = 1'b0;
    endtask
    // Read data stands for one cycle only, so take it at once
    task automatic rd(logic [31:0] a, output logic [31:0] d);
        @(negedge mclk_i);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(negedge mclk_i);
        req.rd = 1'b0;
        d = rdata;
    endtask
    task automatic period(output int n);
        int k;
        n = 0;
        for (k = 0; k < 10 && tick !== 1'b1; k++) @(negedge mclk_i);
        do begin
            @(negedge mclk_i);
            n++;
        end while (tick !== 1'b1 && n < 10);
    endtask
    // Bounded wait for release; counts the wake span before init
    task automatic wait_run();
        int n, w;
        bit seen;
        w = 0;
        seen = 1'b0;
        for (n = 0; n < 300 && sys_n !== 1'b1; n++) begin
            @(negedge mclk_i);
            if (init_en === 1'b1) seen = 1'b1;
            else if (!seen && pin_n === 1'b1) w++;
        end
        chk("released", 1, sys_n);
        chk("init seen", 1, seen);
        chk("wake span", 1, (w >= 6 && w <= 14));
        chk("hv at release", 1, hv_ok);
    endtask
    task automatic pulse(ref logic s, input int n);
        @(negedge mclk_i);
        s = ~s;
        repeat (n) @(negedge mclk_i);
        s = ~s;
    endtask
    task automatic s_boot();
        logic [31:0] d;
        idle = 1'b1;
        rd(GATES_ADDR, d);
        chk("gates reset", GATES_RESET, d);
        rd(DIVIDER_ADDR, d);
        chk("divider reset", 0, d);
        rd(SOURCE_ADDR, d);
        chk("flags power-on", 1, d);
        rd(32'hE01FC104, d);
        chk("unmapped", 0, d);
        chk("units reset", {NUM_UNITS{1'b1}}, units);
        chk("fetch", BOOT_VECTOR, fetch);
        chk("pll keep", 1, pll);
        idle = 1'b0;
    endtask
    task automatic s_gates();
        int pos[NUM_UNITS] = '{TIMER_A_BIT, TIMER_B_BIT, SERIAL_A_BIT,
            SERIAL_B_BIT, PWM_BIT, TWOWIRE_A_BIT, SYNC_A_BIT, CALENDAR_BIT,
            SYNC_B_BIT, CONV_A_BIT, TWOWIRE_B_BIT, CONV_B_BIT};
        logic [31:0] d;
        int n;
        // Converter power-down is never set here, so gates may drop
        for (int i = 0; i < NUM_UNITS; i++) begin
            wr(GATES_ADDR, 32'h1 << pos[i]);
            period(n);
            period(n);
            chk("unit one-hot", 32'h1 << i, units);
        end
        wr(GATES_ADDR, 32'hFFFFFFFF);
        rd(GATES_ADDR, d);
        chk("gates mask", GATES_MASK, d);
    endtask
    task automatic s_div();
        int exp[3] = '{4, 1, 2};
        logic [31:0] d;
        int n;
        for (int i = 0; i < 3; i++) begin
            wr(DIVIDER_ADDR, i);
            rd(DIVIDER_ADDR, d);
            chk("divider", i, d);
            period(n);
            period(n);
            chk("tick period", exp[i], n);
        end
        wr(DIVIDER_ADDR, DIV_RESERVED);
        rd(DIVIDER_ADDR, d);
        chk("divider kept", DIV_HALF, d);
        period(n);
        chk("period kept", 2, n);
    endtask
    task automatic s_flags();
        logic [31:0] d;
        int k, low;
        wr(SOURCE_ADDR, 32'hF);
        rd(SOURCE_ADDR, d);
        chk("flags cleared", 0, d);
        cfg = 2'h2;
        len = 8'h28;
        pulse(go, 1);
        repeat (45) @(negedge mclk_i);
        wait_run();
        rd(SOURCE_ADDR, d);
        chk("flags pin", 32'h2, d);
        chk("cfg latched", 2, cfg_l);
        cfg = 2'h1;
        pulse(wdog, 1);
        repeat (3) @(negedge mclk_i);
        wait_run();
        rd(SOURCE_ADDR, d);
        chk("flags watchdog", 32'h6, d);
        chk("cfg kept", 2, cfg_l);
        pulse(brownout_detector, 3);
        repeat (3) @(negedge mclk_i);
        wait_run();
        rd(SOURCE_ADDR, d);
        chk("flags brownout", 32'hA, d);
        wr(SOURCE_ADDR, 32'h2);
        rd(SOURCE_ADDR, d);
        chk("flag one cleared", 32'h8, d);
        // Short pin glitch and an unarmed watchdog must not reset
        // A reset would finish within the wait, so watch every cycle
        wd_en = 1'b0;
        len = 8'h05;
        pulse(go, 1);
        pulse(wdog, 1);
        low = 0;
        for (k = 0; k < 40; k++) begin
            @(negedge mclk_i);
            if (sys_n !== 1'b1) low++;
        end
        chk("no reset", 0, low);
        rd(SOURCE_ADDR, d);
        chk("flags unchanged", 32'h8, d);
        wd_en = 1'b1;
    endtask
    task automatic s_flash();
        int n;
        busy = 1'b1;
        pulse(wdog, 1);
        for (n = 0; n < 4 && abort !== 1'b1; n++) @(negedge mclk_i);
        chk("flash abort", 1, abort);
        busy = 1'b0;
        wait_run();
    endtask
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        repeat (10) @(negedge mclk_i);
        rst_n_i = 1'b1;
        // Power-on outlasts the local release so its flag logic runs
        repeat (4) @(negedge mclk_i);
        pwr = 1'b0;
        wait_run();
        s_boot();
        s_gates();
        s_div();
        s_flags();
        s_flash();
        print_verdict();
    end
endmodule
`default_nettype wire
